// [bbcd_top.sv]
// Functional notes
// - each second tick refreshes date/time on display
// - battery: calendar counts, no display updates
// - supply drop to battery raises detector interrupt
// - detector disables tick on loss, re-enables on return
// - top YY/MM/DD, bottom hh:mm:ss right-aligned
// - battery: main clock, peripherals stopped, pins released
// - no reset triggered during battery operation
// - select crystal first, then clear oscillator stop
// - i2c standard mode, clock/2, 80000 bps, done interrupt
// - i2c port own address is 0x10
// - calendar runs from 128 Hz, 24-hour format
// - one-hertz output pin kept disabled
// - calendar starts 2000/1/1 Friday 00:00:00
// - periodic calendar interrupt enabled, 1.0 second
// - calendar interrupt priority level 2
`timescale 1ns/1ps
`include "bbcd_regs.svh"

module bbcd_top #(
  parameter int CMD_WAIT_CYCLES = `BBCD_CMD_WAIT_CYC
) (
  input  wire logic       CLK,             // system clock, 40 MHz
  input  wire logic       RESETN,          // asynchronous reset, active low
  input  wire logic       TICK_128HZ,      // one-cycle pulse at 128 Hz
  input  wire logic       MAIN_POWER_OK,   // supply detector: high on main power
  input  wire logic       SCL_I,           // i2c clock line level
  input  wire logic       SDA_I,           // i2c data line level
  output logic            SCL_O,           // i2c clock drive value
  output logic            SCL_OE_N,        // low while driving the clock line
  output logic            SDA_O,           // i2c data drive value
  output logic            SDA_OE_N,        // low while driving the data line
  output logic            MAIN_OSC_SELECT, // crystal mode select
  output logic            MAIN_OSC_STOP,   // main oscillator stopped
  output logic            PERIPH_STOP,     // peripherals stopped
  output logic            ONE_HERTZ_OUT,   // one-hertz pin, disabled
  output logic            SUPPLY_IRQ,      // pulse on switch to battery
  output logic            TICK_IRQ,        // pulse each second while enabled
  output logic            TICK_IRQ_EN,     // periodic interrupt enabled
  output logic [1:0]      TICK_IRQ_LEVEL,  // periodic interrupt priority
  output logic            I2C_DONE_IRQ,    // pulse per finished i2c operation
  output logic            I2C_ACK_ERR,     // last byte not acknowledged
  output logic [6:0]      I2C_OWN_ADDR,    // i2c port local address
  output logic            LCD_READY,       // display initialised
  output logic            LCD_BUSY,        // display transfer in progress
  output logic [7:0]      YEAR,            // packed decimal, 00 = 2000
  output logic [7:0]      MONTH,           // packed decimal
  output logic [7:0]      DAY,             // packed decimal
  output logic [2:0]      WEEKDAY,         // 0 = Sunday
  output logic [7:0]      HOUR,            // packed decimal, 24-hour
  output logic [7:0]      MINUTE,          // packed decimal
  output logic [7:0]      SECOND           // packed decimal
);
  import bbcd_pkg::*;

  localparam logic [6:0]  SUB_LAST  = 7'(`BBCD_TICKS_PER_SEC - 1);
  localparam logic [17:0] WAIT_LAST = 18'(CMD_WAIT_CYCLES - 1);
  localparam logic [4:0]  DATA_LAST = 5'(`BBCD_LINE_CHARS + 1);

  logic rst_meta_r, rst_n_r;
  logic pwr_prev_r, supply_irq_r, tick_en_r, osc_sel_r, osc_stop_r;
  logic [6:0] sub_r;
  logic [7:0] year_r, month_r, day_r, hour_r, min_r, sec_r;
  logic [2:0] wday_r;
  logic sec_tick, tick_irq_r, refresh_pend_r, refresh_take;
  bbcd_seq_t seq_r;
  logic [2:0]  job_r;
  logic [4:0]  bidx_r;
  logic [17:0] wait_r;
  logic        issued_r, init_done_r, is_data;
  logic [7:0]  snap_y_r, snap_mo_r, snap_d_r, snap_h_r, snap_mi_r, snap_s_r;
  logic        op_valid, op_ready, op_done, abort;
  bbcd_op_t    op;
  logic [7:0]  op_byte;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02)                                                month_days = leap ? 8'h29 : 8'h28;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) month_days = 8'h30;
    else                                                           month_days = 8'h31;
  endfunction : month_days

  function automatic logic [7:0] digit(input logic [3:0] n);
    digit = {4'h3, n};
  endfunction : digit

  function automatic logic [7:0] char_at(input logic bottom, input logic [3:0] pos);
    logic [7:0] f;
    f = 8'h00;
    char_at = 8'h20;
    if (!bottom) begin
      f = (pos < 4'h3) ? snap_y_r : (pos < 4'h6) ? snap_mo_r : snap_d_r;
      if (pos == 4'h2 || pos == 4'h5) char_at = 8'h2f;
      else if (pos < 4'h8)            char_at = (pos == 4'h0 || pos == 4'h3 || pos == 4'h6)
                                                ? digit(f[7:4]) : digit(f[3:0]);
    end else begin
      f = (pos < 4'hb) ? snap_h_r : (pos < 4'he) ? snap_mi_r : snap_s_r;
      if (pos == 4'ha || pos == 4'hd) char_at = 8'h3a;
      else if (pos >= 4'h8)           char_at = (pos == 4'h8 || pos == 4'hb || pos == 4'he)
                                                ? digit(f[7:4]) : digit(f[3:0]);
    end
  endfunction : char_at

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // supply detector and periodic interrupt gating
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwr_prev_r   <= 1'b1;
      supply_irq_r <= 1'b0;
      tick_en_r    <= 1'b1;
    end else begin
      pwr_prev_r   <= MAIN_POWER_OK;
      supply_irq_r <= pwr_prev_r && !MAIN_POWER_OK;
      if (pwr_prev_r && !MAIN_POWER_OK) tick_en_r <= 1'b0;
      else if (!pwr_prev_r && MAIN_POWER_OK) tick_en_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_sel_r  <= 1'b0;
      osc_stop_r <= 1'b1;
    end else begin
      osc_sel_r <= 1'b1;
      if (!MAIN_POWER_OK) osc_stop_r <= 1'b1;
      else if (osc_sel_r) osc_stop_r <= 1'b0;
    end
  end

  // calendar keeps counting on either supply; supply changes never reset it
  assign sec_tick = TICK_128HZ && (sub_r == SUB_LAST);

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sub_r   <= 7'h00;
      year_r  <= `BBCD_INIT_YEAR;
      month_r <= `BBCD_INIT_MONTH;
      day_r   <= `BBCD_INIT_DAY;
      wday_r  <= `BBCD_INIT_WDAY;
      hour_r  <= `BBCD_INIT_TIME;
      min_r   <= `BBCD_INIT_TIME;
      sec_r   <= `BBCD_INIT_TIME;
    end else begin
      if (TICK_128HZ) sub_r <= (sub_r == SUB_LAST) ? 7'h00 : sub_r + 7'h01;
      if (sec_tick) begin
        sec_r <= (sec_r == 8'h59) ? 8'h00 : bcd_inc(sec_r);
        if (sec_r == 8'h59) begin
          min_r <= (min_r == 8'h59) ? 8'h00 : bcd_inc(min_r);
          if (min_r == 8'h59) begin
            hour_r <= (hour_r == 8'h23) ? 8'h00 : bcd_inc(hour_r);
            if (hour_r == 8'h23) begin
              wday_r <= (wday_r == 3'h6) ? 3'h0 : wday_r + 3'h1;
              day_r  <= (day_r == month_days(month_r, year_r)) ? 8'h01 : bcd_inc(day_r);
              if (day_r == month_days(month_r, year_r)) begin
                month_r <= (month_r == 8'h12) ? 8'h01 : bcd_inc(month_r);
                if (month_r == 8'h12) year_r <= (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_irq_r     <= 1'b0;
      refresh_pend_r <= 1'b0;
    end else begin
      tick_irq_r <= sec_tick && tick_en_r;
      if (!MAIN_POWER_OK) refresh_pend_r <= 1'b0;
      else if (tick_irq_r) refresh_pend_r <= 1'b1;
      else if (refresh_take) refresh_pend_r <= 1'b0;
    end
  end

  // display sequencer: jobs 0-3 initialise, 4-7 write both lines
  assign is_data      = (job_r == 3'd5) || (job_r == 3'd7);
  assign refresh_take = (seq_r == SEQ_IDLE) && MAIN_POWER_OK && init_done_r && refresh_pend_r;
  assign abort        = !MAIN_POWER_OK;
  assign op_valid     = !issued_r && op_ready && MAIN_POWER_OK && (seq_r != SEQ_IDLE)
                        && (seq_r != SEQ_WAIT);
  assign op           = (seq_r == SEQ_START) ? OP_START : (seq_r == SEQ_BYTE) ? OP_WRITE : OP_STOP;

  always_comb begin
    op_byte = `BBCD_LCD_ADDR_W;
    if (bidx_r == 5'd1) op_byte = is_data ? `BBCD_CTRL_DATA : `BBCD_CTRL_CMD;
    else if (bidx_r != 5'd0 && is_data) op_byte = char_at(job_r[1], 4'(bidx_r - 5'd2));
    else if (bidx_r != 5'd0) begin
      case (job_r)
        3'd0:    op_byte = `BBCD_CMD_FUNC;
        3'd1:    op_byte = `BBCD_CMD_DISP;
        3'd2:    op_byte = `BBCD_CMD_ENTRY;
        3'd3:    op_byte = `BBCD_CMD_CLEAR;
        3'd4:    op_byte = `BBCD_CMD_LINE_TOP;
        default: op_byte = `BBCD_CMD_LINE_BOT;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      seq_r <= SEQ_IDLE;
      job_r <= 3'd0;
      bidx_r <= 5'd0;
      wait_r <= 18'h00000;
      issued_r <= 1'b0;
      init_done_r <= 1'b0;
    end else if (!MAIN_POWER_OK) begin
      seq_r       <= SEQ_IDLE;
      issued_r    <= 1'b0;
      init_done_r <= 1'b0;
    end else begin
      if (op_valid) issued_r <= 1'b1;
      case (seq_r)
        SEQ_IDLE: begin
          if (!init_done_r) begin
            job_r <= 3'd0;
            seq_r <= SEQ_START;
          end else if (refresh_pend_r) begin
            job_r <= 3'd4;
            seq_r <= SEQ_START;
          end
        end
        SEQ_START: if (op_done) begin
          issued_r <= 1'b0;
          bidx_r   <= 5'd0;
          seq_r    <= SEQ_BYTE;
        end
        SEQ_BYTE: if (op_done) begin
          issued_r <= 1'b0;
          bidx_r   <= bidx_r + 5'd1;
          if (bidx_r == (is_data ? DATA_LAST : 5'd2)) seq_r <= SEQ_STOP;
        end
        SEQ_STOP: if (op_done) begin
          issued_r <= 1'b0;
          wait_r   <= 18'h00000;
          if (!is_data) seq_r <= SEQ_WAIT;
          else if (job_r == 3'd7) seq_r <= SEQ_IDLE;
          else begin
            job_r <= job_r + 3'd1;
            seq_r <= SEQ_START;
          end
        end
        default: begin
          wait_r <= wait_r + 18'h00001;
          if (wait_r == WAIT_LAST) begin
            if (job_r == 3'd3) begin
              init_done_r <= 1'b1;
              seq_r       <= SEQ_IDLE;
            end else begin
              job_r <= job_r + 3'd1;
              seq_r <= SEQ_START;
            end
          end
        end
      endcase
    end
  end

  // date and time frozen for the whole refresh
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      snap_y_r  <= 8'h00;
      snap_mo_r <= 8'h00;
      snap_d_r  <= 8'h00;
      snap_h_r  <= 8'h00;
      snap_mi_r <= 8'h00;
      snap_s_r  <= 8'h00;
    end else if (refresh_take) begin
      snap_y_r  <= year_r;
      snap_mo_r <= month_r;
      snap_d_r  <= day_r;
      snap_h_r  <= hour_r;
      snap_mi_r <= min_r;
      snap_s_r  <= sec_r;
    end
  end

  bbcd_i2c_byte bbcd_i2c_byte_inst (
    .clk      (CLK),
    .rst_n    (rst_n_r),
    .abort    (abort),
    .op_valid (op_valid),
    .op       (op),
    .op_byte  (op_byte),
    .op_ready (op_ready),
    .done     (op_done),
    .ack_err  (I2C_ACK_ERR),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .scl_oe_n (SCL_OE_N),
    .sda_oe_n (SDA_OE_N)
  );

  assign SCL_O           = 1'b0;
  assign SDA_O           = 1'b0;
  assign MAIN_OSC_SELECT = osc_sel_r;
  assign MAIN_OSC_STOP   = osc_stop_r;
  assign PERIPH_STOP     = !MAIN_POWER_OK;
  assign ONE_HERTZ_OUT   = 1'b0;
  assign SUPPLY_IRQ      = supply_irq_r;
  assign TICK_IRQ        = tick_irq_r;
  assign TICK_IRQ_EN     = tick_en_r;
  assign TICK_IRQ_LEVEL  = `BBCD_TICK_LEVEL;
  assign I2C_DONE_IRQ    = op_done;
  assign I2C_OWN_ADDR    = `BBCD_OWN_ADDR;
  assign LCD_READY       = init_done_r;
  assign LCD_BUSY        = (seq_r != SEQ_IDLE);
  assign YEAR            = year_r;
  assign MONTH           = month_r;
  assign DAY             = day_r;
  assign WEEKDAY         = wday_r;
  assign HOUR            = hour_r;
  assign MINUTE          = min_r;
  assign SECOND          = sec_r;

endmodule : bbcd_top

// [bbcd_regs.svh]
`ifndef BBCD_REGS_SVH
`define BBCD_REGS_SVH

// timing
`define BBCD_CLK_HZ          40000000
`define BBCD_I2C_BPS         80000
`define BBCD_I2C_DIV         2
// quarter-bit length in prescaled clocks, rounded up so the rate never exceeds the target
`define BBCD_I2C_QTR         ((`BBCD_CLK_HZ / `BBCD_I2C_DIV + 4 * `BBCD_I2C_BPS - 1) / (4 * `BBCD_I2C_BPS))
`define BBCD_CMD_WAIT_MS     5
`define BBCD_CMD_WAIT_CYC    (`BBCD_CLK_HZ / 1000 * `BBCD_CMD_WAIT_MS)
`define BBCD_TICKS_PER_SEC   128

// i2c port and display addressing
`define BBCD_OWN_ADDR        7'h10
`define BBCD_LCD_ADDR_W      8'ha0
`define BBCD_CTRL_CMD        8'h00
`define BBCD_CTRL_DATA       8'h80
`define BBCD_CMD_FUNC        8'h38
`define BBCD_CMD_DISP        8'h0c
`define BBCD_CMD_ENTRY       8'h06
`define BBCD_CMD_CLEAR       8'h01
`define BBCD_CMD_LINE_TOP    8'h80
`define BBCD_CMD_LINE_BOT    8'hc0
`define BBCD_LINE_CHARS      16

// calendar reset values and interrupt level
`define BBCD_INIT_YEAR       8'h00
`define BBCD_INIT_MONTH      8'h01
`define BBCD_INIT_DAY        8'h01
`define BBCD_INIT_WDAY       3'h5
`define BBCD_INIT_TIME       8'h00
`define BBCD_TICK_LEVEL      2'h2

`endif

// [bbcd_pkg.sv]
package bbcd_pkg;

  typedef enum logic [3:0] {
    I2C_IDLE  = 4'b0001,
    I2C_START = 4'b0010,
    I2C_BIT   = 4'b0100,
    I2C_STOP  = 4'b1000
  } bbcd_i2c_st_t;

  typedef enum logic [2:0] {
    OP_START = 3'b001,
    OP_WRITE = 3'b010,
    OP_STOP  = 3'b100
  } bbcd_op_t;

  typedef enum logic [4:0] {
    SEQ_IDLE  = 5'b00001,
    SEQ_START = 5'b00010,
    SEQ_BYTE  = 5'b00100,
    SEQ_STOP  = 5'b01000,
    SEQ_WAIT  = 5'b10000
  } bbcd_seq_t;

endpackage : bbcd_pkg

// [bbcd_i2c_byte.sv]
`timescale 1ns/1ps
`include "bbcd_regs.svh"

module bbcd_i2c_byte (
  input  wire logic             clk,       // system clock
  input  wire logic             rst_n,     // synchronised reset, active low
  input  wire logic             abort,     // drop everything and release the pins
  input  wire logic             op_valid,  // operation request
  input  wire bbcd_pkg::bbcd_op_t op,      // start, write or stop
  input  wire logic [7:0]       op_byte,   // byte for a write
  output logic                  op_ready,  // engine idle
  output logic                  done,      // one-cycle pulse at the end of an operation
  output logic                  ack_err,   // last written byte was not acknowledged
  input  wire logic             scl_i,     // clock line level
  input  wire logic             sda_i,     // data line level
  output logic                  scl_oe_n,  // low while pulling the clock line low
  output logic                  sda_oe_n   // low while pulling the data line low
);
  import bbcd_pkg::*;

  localparam logic [5:0] QTR_LAST = 6'(`BBCD_I2C_QTR - 1);

  bbcd_i2c_st_t st_r;
  logic         pre_r;
  logic [5:0]   qcnt_r;
  logic [1:0]   ph_r;
  logic [3:0]   bit_r;
  logic [7:0]   sh_r;
  logic         scl_low_r;
  logic         sda_low_r;
  logic         done_r;
  logic         ack_err_r;
  logic         step;

  // quarter-bit step; held while a slave stretches the clock during a write, not during a stop
  assign step = pre_r && (qcnt_r == QTR_LAST) && !(st_r == I2C_BIT && ph_r == 2'd1 && !scl_i);
  assign op_ready = (st_r == I2C_IDLE);
  assign done     = done_r;
  assign ack_err  = ack_err_r;
  assign scl_oe_n = ~scl_low_r;
  assign sda_oe_n = ~sda_low_r;

  // operation clock is the system clock divided by two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 1'b0;
    end else begin
      pre_r <= ~pre_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt_r <= 6'h00;
    end else if (abort || st_r == I2C_IDLE) begin
      qcnt_r <= 6'h00;
    end else if (pre_r) begin
      qcnt_r <= (qcnt_r == QTR_LAST) ? 6'h00 : qcnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= I2C_IDLE;
      ph_r      <= 2'd0;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      done_r    <= 1'b0;
      ack_err_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        st_r      <= I2C_IDLE;
        scl_low_r <= 1'b0;
        sda_low_r <= 1'b0;
      end else begin
        case (st_r)
          I2C_IDLE: begin
            ph_r <= 2'd0;
            if (op_valid) begin
              case (op)
                OP_START: st_r <= I2C_START;
                OP_WRITE: begin
                  st_r      <= I2C_BIT;
                  sh_r      <= op_byte;
                  bit_r     <= 4'h0;
                  sda_low_r <= ~op_byte[7];
                end
                default:  st_r <= I2C_STOP;
              endcase
            end
          end
          I2C_START: begin
            if (step) begin
              ph_r <= ph_r + 2'd1;
              case (ph_r)
                2'd0: sda_low_r <= 1'b1;
                2'd2: scl_low_r <= 1'b1;
                2'd3: begin
                  st_r   <= I2C_IDLE;
                  done_r <= 1'b1;
                end
                default: ;
              endcase
            end
          end
          I2C_BIT: begin
            if (step) begin
              ph_r <= ph_r + 2'd1;
              case (ph_r)
                2'd0: scl_low_r <= 1'b0;
                2'd1: if (bit_r == 4'h8) ack_err_r <= sda_i;
                2'd2: scl_low_r <= 1'b1;
                default: begin
                  if (bit_r == 4'h8) begin
                    st_r      <= I2C_IDLE;
                    done_r    <= 1'b1;
                    sda_low_r <= 1'b0;
                  end else begin
                    bit_r     <= bit_r + 4'h1;
                    sh_r      <= {sh_r[6:0], 1'b0};
                    // release data for the acknowledge slot
                    sda_low_r <= (bit_r == 4'h7) ? 1'b0 : ~sh_r[6];
                  end
                end
              endcase
            end
          end
          default: begin
            if (step) begin
              ph_r <= ph_r + 2'd1;
              case (ph_r)
                2'd0: sda_low_r <= 1'b1;
                2'd1: scl_low_r <= 1'b0;
                2'd2: sda_low_r <= 1'b0;
                default: begin
                  st_r   <= I2C_IDLE;
                  done_r <= 1'b1;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule : bbcd_i2c_byte

// [bbcd_top_props.sv]
`timescale 1ns/1ps
module bbcd_top_props (
  input wire logic       CLK,             // clock
  input wire logic       RESETN,          // reset
  input wire logic       MAIN_POWER_OK,   // supply
  input wire logic       SUPPLY_IRQ,      // detector pulse
  input wire logic       TICK_IRQ,        // second pulse
  input wire logic       TICK_IRQ_EN,     // tick enable
  input wire logic       SCL_OE_N,        // clock drive
  input wire logic       SDA_OE_N,        // data drive
  input wire logic       MAIN_OSC_SELECT, // crystal mode
  input wire logic       MAIN_OSC_STOP,   // osc stopped
  input wire logic       PERIPH_STOP,     // periph stopped
  input wire logic       ONE_HERTZ_OUT,   // 1 hz pin
  input wire logic [1:0] TICK_IRQ_LEVEL,  // priority
  input wire logic [6:0] I2C_OWN_ADDR,    // own address
  input wire logic       LCD_READY,       // init done
  input wire logic       LCD_BUSY         // link busy
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  chk_supply_irq: assert property ($fell(MAIN_POWER_OK) |-> ##[1:3] SUPPLY_IRQ)
    else $error("supply pulse missing");
  chk_tick_off_batt: assert property (!MAIN_POWER_OK [*5] |-> !TICK_IRQ_EN && !TICK_IRQ)
    else $error("tick alive on battery");
  chk_tick_back: assert property ($rose(MAIN_POWER_OK) |-> ##[1:3] TICK_IRQ_EN)
    else $error("tick not re-enabled");
  chk_pins_free: assert property (!MAIN_POWER_OK [*5] |->
    SCL_OE_N && SDA_OE_N && MAIN_OSC_STOP && PERIPH_STOP)
    else $error("battery drain");
  chk_lcd_idle_batt: assert property (!MAIN_POWER_OK [*5] |-> !LCD_BUSY && !LCD_READY)
    else $error("display active on battery");
  chk_tick_pulse: assert property (TICK_IRQ |=> !TICK_IRQ [*8])
    else $error("tick pulse too long");
  chk_osc_order: assert property (!MAIN_OSC_STOP |-> MAIN_OSC_SELECT)
    else $error("osc started before select");
  chk_fixed_out: assert property (!ONE_HERTZ_OUT && TICK_IRQ_LEVEL == 2'h2
    && I2C_OWN_ADDR == 7'h10)
    else $error("fixed output wrong");
endmodule : bbcd_top_props

bind bbcd_top bbcd_top_props bbcd_top_props_inst (.CLK, .RESETN, .MAIN_POWER_OK, .SUPPLY_IRQ,
  .TICK_IRQ, .TICK_IRQ_EN, .SCL_OE_N, .SDA_OE_N, .MAIN_OSC_SELECT, .MAIN_OSC_STOP,
  .PERIPH_STOP, .ONE_HERTZ_OUT, .TICK_IRQ_LEVEL, .I2C_OWN_ADDR, .LCD_READY, .LCD_BUSY);

// [bbcd_lcd_model.sv]
`timescale 1ns/1ps
module bbcd_lcd_model (
  input  wire logic clk,        // sampling clock
  input  wire logic scl,        // clock line
  input  wire logic sda,        // data line
  output logic      ack_oe_n,   // low while pulling data low
  output logic      byte_valid, // one pulse per byte
  output logic [7:0] byte_data  // received byte
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [3:0] cnt = 4'h0;
  initial ack_oe_n = 1'b1;
  initial byte_valid = 1'b0;
  always @(posedge clk) begin
    byte_valid <= 1'b0;
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) cnt <= 4'h0;
    else if (scl && !scl_q && cnt < 4'h8) begin
      sh  <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
    end else if (!scl && scl_q && cnt == 4'h8) begin
      ack_oe_n   <= 1'b0; // every setting byte is accepted
      byte_valid <= 1'b1;
      byte_data  <= sh;
      cnt        <= 4'h9;
    end else if (!scl && scl_q && cnt == 4'h9) begin
      ack_oe_n <= 1'b1;
      cnt      <= 4'h0;
    end
  end
endmodule : bbcd_lcd_model

// [tb_bbcd_top.sv]
`timescale 1ns/1ps
module tb_bbcd_top;
  logic CLK = 0, RESETN = 0, TICK_128HZ = 0, MAIN_POWER_OK = 1;
  logic SCL_I, SDA_I, SCL_O, SCL_OE_N, SDA_O, SDA_OE_N, MAIN_OSC_SELECT, MAIN_OSC_STOP;
  logic PERIPH_STOP, ONE_HERTZ_OUT, SUPPLY_IRQ, TICK_IRQ, TICK_IRQ_EN, I2C_DONE_IRQ;
  logic I2C_ACK_ERR, LCD_READY, LCD_BUSY, ack_oe_n, byte_valid;
  logic [1:0] TICK_IRQ_LEVEL;
  logic [6:0] I2C_OWN_ADDR;
  logic [2:0] WEEKDAY;
  logic [7:0] YEAR, MONTH, DAY, HOUR, MINUTE, SECOND, byte_data;
  logic [15:0] time_q[$];
  logic [7:0] byte_q[$];
  int errors = 0, num_checks = 0, secs = 0, supplies = 0;

  initial forever #12.5 CLK = ~CLK;
  assign SCL_I = SCL_OE_N; // pull-up, display never stretches
  assign SDA_I = SDA_OE_N & ack_oe_n;

  bbcd_top #(.CMD_WAIT_CYCLES(20)) bbcd_top_inst (.CLK, .RESETN, .TICK_128HZ,
    .MAIN_POWER_OK, .SCL_I, .SDA_I, .SCL_O, .SCL_OE_N, .SDA_O, .SDA_OE_N, .MAIN_OSC_SELECT,
    .MAIN_OSC_STOP, .PERIPH_STOP, .ONE_HERTZ_OUT, .SUPPLY_IRQ, .TICK_IRQ, .TICK_IRQ_EN,
    .TICK_IRQ_LEVEL, .I2C_DONE_IRQ, .I2C_ACK_ERR, .I2C_OWN_ADDR, .LCD_READY, .LCD_BUSY,
    .YEAR, .MONTH, .DAY, .WEEKDAY, .HOUR, .MINUTE, .SECOND);
  bbcd_lcd_model bbcd_lcd_model_inst (.clk(CLK), .scl(SCL_I), .sda(SDA_I), .ack_oe_n,
    .byte_valid, .byte_data);

  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction : bcd

  task automatic tick;
    repeat ($urandom % 2) @(posedge CLK);
    @(posedge CLK) #2 TICK_128HZ = 1;
    @(posedge CLK) #2 TICK_128HZ = 0;
  endtask : tick

  task automatic second(input bit note);
    repeat (128) tick;
    secs++;
    if (note) time_q.push_back({bcd(secs / 60), bcd(secs % 60)});
  endtask : second

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  always @(posedge CLK) begin
    if (SUPPLY_IRQ === 1'b1) supplies++;
    if (TICK_IRQ === 1'b1) begin
      if (time_q.size() == 0) check("tick", 16'h1, 16'h0);
      else check("time", {MINUTE, SECOND}, time_q.pop_front());
    end
    if (byte_valid === 1'b1) begin
      if (byte_q.size() == 0) check("byte", 16'h1, 16'h0);
      else check("byte", byte_data, byte_q.pop_front());
    end
  end

  initial begin
    #4000000;
    errors++;
    $display("timeout");
    conclude;
  end

  initial begin
    void'($urandom(46));
    repeat (5) @(posedge CLK);
    check("date", {YEAR, MONTH}, 16'h0001);
    check("day", {DAY, 5'h0, WEEKDAY}, 16'h0105);
    check("clock", {HOUR, MINUTE}, 16'h0000);
    $display("reset test done");
    #2 RESETN = 1;
    byte_q = {8'ha0, 8'h00, 8'h38, 8'ha0, 8'h00, 8'h0c,
              8'ha0, 8'h00, 8'h06, 8'ha0, 8'h00, 8'h01};
    repeat (6) @(posedge CLK);
    check("osc", {MAIN_OSC_SELECT, MAIN_OSC_STOP}, 16'h2);
    check("one hertz", ONE_HERTZ_OUT, 16'h0);
    check("level", TICK_IRQ_LEVEL, 16'h2);
    check("own addr", I2C_OWN_ADDR, 16'h10);
    repeat (61) second(1);
    $display("calendar test done");
    for (int i = 0; i < 100000 && LCD_READY !== 1'b1; i++) @(posedge CLK);
    check("init left", 16'(byte_q.size()), 16'h0);
    byte_q = {8'ha0, 8'h00, 8'h80, 8'ha0, 8'h80, 8'h30, 8'h30};
    second(1);
    for (int i = 0; i < 100000 && byte_q.size() != 0; i++) @(posedge CLK);
    check("refresh left", 16'(byte_q.size()), 16'h0);
    $display("refresh test done");
    repeat (1000) @(posedge CLK);
    #2 MAIN_POWER_OK = 0;
    repeat (6) @(posedge CLK);
    check("enable off", TICK_IRQ_EN, 16'h0);
    check("pins", {SCL_OE_N, SDA_OE_N, PERIPH_STOP, MAIN_OSC_STOP}, 16'hf);
    check("lcd ready", LCD_READY, 16'h0);
    check("link idle", {SCL_O, SDA_O, I2C_ACK_ERR, LCD_BUSY}, 16'h0);
    check("supply irq", 16'(supplies), 16'h1);
    second(0);
    check("battery time", {MINUTE, SECOND}, 16'h0103);
    $display("battery test done");
    MAIN_POWER_OK = 1;
    repeat (6) @(posedge CLK);
    check("enable on", TICK_IRQ_EN, 16'h1);
    $display("power return test done");
    conclude;
  end
endmodule : tb_bbcd_top
